//--- bench/lccl_line_model.sv
// Line card side: external devices and pulls seen on every lead.
// Assumes ext_in holds the level the far side sets on an undriven lead.
`timescale 1ns/1ps
module lccl_line_model (
	input  wire [23:0]	drv_in,
	input  wire [23:0]	oe_n_in,
	input  wire [23:0]	ext_in,
	output wire [23:0]	level_out
);
	// A driven lead shows the latch value, an undriven one the far side
	assign level_out = (~oe_n_in & drv_in) | (oe_n_in & ext_in);
endmodule

//--- bench/lccl_top_asserts.sv
// Checker for the latch bank, watching only the top-level ports.
// Assumes one clock domain with the asynchronous active-low reset.
`timescale 1ns/1ps
module lccl_checker #(parameter CHANS = 4, LEADS = 6, CHAN_W = 2) (
	input wire			clock_in,
	input wire			nrst_in,
	input wire [CHAN_W-1:0]		mem_chan_in,
	input wire [7:0]		mem_addr_in,
	input wire			mem_wr_in,
	input wire			mem_rd_in,
	input wire [7:0]		mem_wdata_in,
	input wire [7:0]		mem_rdata_out,
	input wire			mem_rvalid_out,
	input wire			mem_hit_out,
	input wire			mem_wr_reject_out,
	input wire			scan_req_in,
	input wire [7:0]		scan_data_out,
	input wire			scan_valid_out,
	input wire [CHANS-1:0]		chan_reset_in,
	input wire [CHANS*LEADS-1:0]	lead_in,
	input wire [CHANS*LEADS-1:0]	lead_out,
	input wire [CHANS*LEADS-1:0]	lead_oe_n_out
);
	logic [7:0] sc;
	always_comb for (int n = 0; n < 4; n++) sc[2*n +: 2] = lead_in[n*LEADS +: 2];
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	a_read_answer: assert property (mem_rd_in |=> mem_rvalid_out && mem_rdata_out[7:6] == 2'h0)
		else $error("read not answered");
	a_state_read: assert property (mem_rd_in && mem_addr_in == 8'hA0 && $stable(lead_in) |=>
		mem_rdata_out[5:0] == 6'($past(lead_in) >> ($past(mem_chan_in) * LEADS))) else $error("bad state");
	a_scan_byte: assert property (scan_req_in && $stable(lead_in) |=> scan_valid_out && scan_data_out == $past(sc))
		else $error("bad scan");
	a_dir_write: assert property (mem_wr_in && mem_addr_in == 8'h9E && chan_reset_in == 0 |=>
		lead_oe_n_out[$past(mem_chan_in)*LEADS +: 6] == ~$past(mem_wdata_in[5:0])) else $error("bad dir");
	a_value_write: assert property (mem_wr_in && mem_addr_in == 8'h9F && chan_reset_in == 0 |=>
		lead_out[$past(mem_chan_in)*LEADS +: 6] == $past(mem_wdata_in[5:0])) else $error("bad value");
	a_chan_reset: assert property (chan_reset_in[0] |=> lead_oe_n_out[5:0] == 6'h33 && lead_out[5:0] == 6'h00)
		else $error("bad chan reset");
	a_write_refused: assert property (mem_wr_in && (mem_addr_in == 8'hA0 || mem_addr_in > 8'hA2) |-> mem_wr_reject_out)
		else $error("write not refused");
	a_read_quiet: assert property (mem_rd_in && !mem_wr_in && chan_reset_in == 0 |=> $stable(lead_oe_n_out))
		else $error("read disturbed leads");
	a_hit_decode: assert property (mem_hit_out == ((mem_wr_in || mem_rd_in) &&
		(mem_addr_in == 8'h9E || mem_addr_in == 8'h9F || mem_addr_in == 8'hA0))) else $error("bad hit");
endmodule
bind lccl_top lccl_checker #(.CHANS(CHANS), .LEADS(LEADS), .CHAN_W(CHAN_W)) u_chk (
	.clock_in          (clock_in),
	.nrst_in           (nrst_in),
	.mem_chan_in       (mem_chan_in),
	.mem_addr_in       (mem_addr_in),
	.mem_wr_in         (mem_wr_in),
	.mem_rd_in         (mem_rd_in),
	.mem_wdata_in      (mem_wdata_in),
	.mem_rdata_out     (mem_rdata_out),
	.mem_rvalid_out    (mem_rvalid_out),
	.mem_hit_out       (mem_hit_out),
	.mem_wr_reject_out (mem_wr_reject_out),
	.scan_req_in       (scan_req_in),
	.scan_data_out     (scan_data_out),
	.scan_valid_out    (scan_valid_out),
	.chan_reset_in     (chan_reset_in),
	.lead_in           (lead_in),
	.lead_out          (lead_out),
	.lead_oe_n_out     (lead_oe_n_out)
);

//--- bench/line_card_control_latches_bench.sv
// Self-checking bench for the latch bank with a line card model on its leads.
// Assumes the design and the line model are compiled first.
`timescale 1ns/1ps
module line_card_control_latches_bench;
	logic		clock_in, nrst_in, mem_all_in, mem_wr_in, mem_rd_in, scan_req_in;
	logic		mem_rvalid_out, mem_hit_out, mem_wr_reject_out, scan_valid_out;
	logic [1:0]	mem_chan_in, c;
	logic [7:0]	mem_addr_in, mem_wdata_in, mem_rdata_out, scan_data_out, d, v, got, want;
	logic [3:0]	chan_reset_in;
	logic [23:0]	lead_in, lead_out, lead_oe_n_out, ext;
	logic [7:0]	expq[$];
	logic [31:0]	seed = 51;
	int		miscompares = 0;
	int		checks = 0;
	lccl_top i_dut (
		.clock_in          (clock_in),
		.nrst_in           (nrst_in),
		.mem_chan_in       (mem_chan_in),
		.mem_all_in        (mem_all_in),
		.mem_addr_in       (mem_addr_in),
		.mem_wr_in         (mem_wr_in),
		.mem_rd_in         (mem_rd_in),
		.mem_wdata_in      (mem_wdata_in),
		.mem_rdata_out     (mem_rdata_out),
		.mem_rvalid_out    (mem_rvalid_out),
		.mem_hit_out       (mem_hit_out),
		.mem_wr_reject_out (mem_wr_reject_out),
		.scan_req_in       (scan_req_in),
		.scan_data_out     (scan_data_out),
		.scan_valid_out    (scan_valid_out),
		.chan_reset_in     (chan_reset_in),
		.lead_in           (lead_in),
		.lead_out          (lead_out),
		.lead_oe_n_out     (lead_oe_n_out)
	);
	lccl_line_model i_line (.drv_in(lead_out), .oe_n_in(lead_oe_n_out), .ext_in(ext), .level_out(lead_in));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic acc(input logic w, r, input logic [7:0] a, dt, input logic [1:0] ch, input logic all);
		@(posedge clock_in);
		{mem_wr_in, mem_rd_in, mem_addr_in, mem_wdata_in, mem_chan_in, mem_all_in} <= {w, r, a, dt, ch, all};
		@(posedge clock_in);
		{mem_wr_in, mem_rd_in} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] ch, input logic [7:0] e);
		expq.push_back(e);
		acc(1'b0, 1'b1, a, 8'h00, ch, 1'b0);
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	// Results leave in request order, so the oldest note is always the match
	always @(posedge clock_in) begin
		if (mem_rvalid_out === 1'b1 || scan_valid_out === 1'b1) begin
			got = mem_rvalid_out ? mem_rdata_out : scan_data_out;
			want = expq.size() > 0 ? expq.pop_front() : 8'hXX;
			checks++;
			if (got !== want) begin
				$display("FAIL %0t got %h expected %h", $time, got, want);
				miscompares++;
			end
		end
	end
	initial begin
		{nrst_in, mem_all_in, mem_wr_in, mem_rd_in, scan_req_in, mem_chan_in, mem_addr_in, mem_wdata_in} = 0;
		{chan_reset_in, ext} = 0;
		repeat (6) @(posedge clock_in);
		nrst_in <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			rd(8'h9E, 2'(k), 8'h0C);
			rd(8'h9F, 2'(k), 8'h00);
		end
		for (int i = 0; i < 24; i++) begin
			c = 2'(xs());
			d = 8'(xs());
			v = 8'(xs());
			ext <= 24'(xs());
			acc(1'b1, 1'b0, 8'h9E, d, c, 1'b0);
			acc(1'b1, 1'b0, 8'h9F, v, c, 1'b0);
			rd(8'h9E, c, d & 8'h3F);
			rd(8'h9F, c, v & 8'h3F);
			rd(8'hA0, c, {2'h0, d[5:0] & v[5:0] | ~d[5:0] & ext[c*6 +: 6]});
		end
		acc(1'b1, 1'b0, 8'h9E, 8'h3F, 2'h0, 1'b1);
		@(posedge clock_in);
		chan_reset_in <= 4'h1;
		@(posedge clock_in);
		chan_reset_in <= 4'h0;
		for (int k = 0; k < 4; k++) rd(8'h9E, 2'(k), k == 0 ? 8'h0C : 8'h3F);
		acc(1'b1, 1'b0, 8'hA0, 8'h00, 2'h1, 1'b0);
		acc(1'b1, 1'b0, 8'h9D, 8'h00, 2'h1, 1'b0);
		rd(8'h9E, 2'h1, 8'h3F);
		rd(8'h50, 2'h1, 8'h00);
		acc(1'b1, 1'b0, 8'h9E, 8'h00, 2'h0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			ext <= 24'(xs());
			@(posedge clock_in);
			scan_req_in <= 1'b1;
			expq.push_back({ext[19:18], ext[13:12], ext[7:6], ext[1:0]});
			@(posedge clock_in);
			scan_req_in <= 1'b0;
		end
		for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge clock_in);
		if (expq.size() > 0) begin
			$display("FAIL %0t got %h expected %h", $time, 8'h00, expq[0]);
			miscompares++;
		end
		wrap_up();
	end
endmodule

//--- logic/lccl_consts.vh
// Constants for the line card control latch bank: control memory
// locations, latch geometry and the values the leads take at reset.
// Included by every design file of the block; holds definitions only.
`ifndef LCCL_CONSTS_VH
`define LCCL_CONSTS_VH

// Control memory word width and address width
`define LCCL_DATA_W      8
`define LCCL_ADDR_W      8

// Control memory locations served by this block
`define LCCL_ADDR_DIR    8'h9E
`define LCCL_ADDR_OUT    8'h9F
`define LCCL_ADDR_STATE  8'hA0
// Highest location the host may ever write
`define LCCL_ADDR_TOP    8'hA2

// Geometry
`define LCCL_LEADS       6
`define LCCL_CHANS       4
`define LCCL_CHAN_W      2

// Direction encoding: a set bit makes the lead a driven output
`define LCCL_DIR_OUTPUT  1'b1
// Reset state: leads 2 and 3 outputs, the rest inputs; all values zero
`define LCCL_DIR_RST     6'h0C
`define LCCL_OUT_RST     6'h00

// Fast scan reports lead bits 0 and 1 of each channel
`define LCCL_SCAN_LO     0
`define LCCL_SCAN_HI     1
`define LCCL_SCAN_BITS   2

// Unused upper bits of an 8-bit location read as zero
`define LCCL_PAD_ZERO    2'h0
`define LCCL_BYTE_ZERO   8'h00

`endif

//--- logic/lccl_lead.v
// One channel of six bidirectional control latches: direction and
// value storage, pin drive and sampling of the actual lead levels.
// Assumes pin inputs already synchronous to clock_in.
`timescale 1ns/1ps
`include "lccl_consts.vh"

module lccl_lead #(
	parameter LEADS = `LCCL_LEADS
) (
	input  wire             clock_in,
	input  wire             nrst_in,
	input  wire             chan_reset_in,
	input  wire             dir_we_in,
	input  wire             out_we_in,
	input  wire [LEADS-1:0] wdata_in,
	input  wire [LEADS-1:0] pin_in,
	output wire [LEADS-1:0] dir_out,
	output wire [LEADS-1:0] value_out,
	output wire [LEADS-1:0] state_out,
	output wire [LEADS-1:0] pin_out,
	output wire [LEADS-1:0] pin_oe_n_out
);

	reg [LEADS-1:0] dir_reg;
	reg [LEADS-1:0] value_reg;
	reg [LEADS-1:0] state_reg;

	// Direction and value storage; channel reset restores the power-up pattern
	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dir_reg   <= `LCCL_DIR_RST;
			value_reg <= `LCCL_OUT_RST;
		end else if (chan_reset_in) begin
			dir_reg   <= `LCCL_DIR_RST;
			value_reg <= `LCCL_OUT_RST;
		end else begin
			if (dir_we_in)
				dir_reg <= wdata_in;
			if (out_we_in)
				value_reg <= wdata_in;
		end
	end

	// Actual pin level, whatever the direction
	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			state_reg <= {LEADS{1'b0}};
		else
			state_reg <= pin_in;
	end

	// Value always presented; the enable alone decides whether it reaches the pin
	assign pin_out      = value_reg;
	assign pin_oe_n_out = ~dir_reg;
	assign dir_out      = dir_reg;
	assign value_out    = value_reg;
	assign state_out    = state_reg;

endmodule

//--- logic/lccl_top.v
// Line card control latches for all channels, reached through the
// control memory access port of the serial control interface.
// Assumes the serial interface decodes frames and presents one-cycle
// read and write strobes with address, channel and data.
`timescale 1ns/1ps
`include "lccl_consts.vh"

module lccl_top #(
	parameter CHANS  = `LCCL_CHANS,
	parameter LEADS  = `LCCL_LEADS,
	parameter CHAN_W = `LCCL_CHAN_W
) (
	input  wire                     clock_in,
	input  wire                     nrst_in,
	input  wire [CHAN_W-1:0]        mem_chan_in,
	input  wire                     mem_all_in,
	input  wire [`LCCL_ADDR_W-1:0]  mem_addr_in,
	input  wire                     mem_wr_in,
	input  wire                     mem_rd_in,
	input  wire [`LCCL_DATA_W-1:0]  mem_wdata_in,
	output wire [`LCCL_DATA_W-1:0]  mem_rdata_out,
	output wire                     mem_rvalid_out,
	output wire                     mem_hit_out,
	output wire                     mem_wr_reject_out,
	input  wire                     scan_req_in,
	output wire [`LCCL_DATA_W-1:0]  scan_data_out,
	output wire                     scan_valid_out,
	input  wire [CHANS-1:0]         chan_reset_in,
	input  wire [CHANS*LEADS-1:0]   lead_in,
	output wire [CHANS*LEADS-1:0]   lead_out,
	output wire [CHANS*LEADS-1:0]   lead_oe_n_out
);

	// Two scan bits per channel make up the scan byte
	localparam SCAN_W = CHANS * `LCCL_SCAN_BITS;

	// Address decode
	reg  addr_dir;
	reg  addr_out;
	reg  addr_state;
	wire addr_above;

	always @* begin
		addr_dir   = 1'b0;
		addr_out   = 1'b0;
		addr_state = 1'b0;
		case (mem_addr_in)
			`LCCL_ADDR_DIR: begin
				addr_dir = 1'b1;
			end
			`LCCL_ADDR_OUT: begin
				addr_out = 1'b1;
			end
			`LCCL_ADDR_STATE: begin
				addr_state = 1'b1;
			end
			default: begin
				addr_dir = 1'b0;
			end
		endcase
	end

	// Anything above the top location is internal state of the device
	assign addr_above = (mem_addr_in > `LCCL_ADDR_TOP);

	// Combinational strobes: one-cycle qualifiers from the decode
	assign mem_hit_out = (mem_wr_in | mem_rd_in) & (addr_dir | addr_out | addr_state);

	// Status is read-only and everything above the top location holds internal
	// state, so writes there are refused and dropped
	wire wr_to_status;
	wire wr_above_top;

	assign wr_to_status      = mem_wr_in & addr_state;
	assign wr_above_top      = mem_wr_in & addr_above;
	assign mem_wr_reject_out = wr_to_status | wr_above_top;

	// Per-channel write enables; write-all loads every channel at once
	reg [CHANS-1:0] chan_sel;
	integer         i;

	always @* begin
		chan_sel = {CHANS{1'b0}};
		for (i = 0; i < CHANS; i = i + 1) begin
			if (mem_all_in || (mem_chan_in == i[CHAN_W-1:0]))
				chan_sel[i] = 1'b1;
		end
	end

	// Only the two writable locations raise enables; refused writes reach no bank
	wire [CHANS-1:0] dir_we;
	wire [CHANS-1:0] out_we;

	assign dir_we = (mem_wr_in && addr_dir) ? chan_sel : {CHANS{1'b0}};
	assign out_we = (mem_wr_in && addr_out) ? chan_sel : {CHANS{1'b0}};

	// Latch banks, one per channel
	// Each bank samples all its leads on every edge, whatever their direction
	wire [CHANS*LEADS-1:0] dir_all;
	wire [CHANS*LEADS-1:0] value_all;
	wire [CHANS*LEADS-1:0] state_all;

	genvar g;
	generate
		for (g = 0; g < CHANS; g = g + 1) begin : chan
			lccl_lead #(
				.LEADS (LEADS)
			) u_lead (
				.clock_in      (clock_in),
				.nrst_in       (nrst_in),
				.chan_reset_in (chan_reset_in[g]),
				.dir_we_in     (dir_we[g]),
				.out_we_in     (out_we[g]),
				.wdata_in      (mem_wdata_in[LEADS-1:0]),
				.pin_in        (lead_in[g*LEADS +: LEADS]),
				.dir_out       (dir_all[g*LEADS +: LEADS]),
				.value_out     (value_all[g*LEADS +: LEADS]),
				.state_out     (state_all[g*LEADS +: LEADS]),
				.pin_out       (lead_out[g*LEADS +: LEADS]),
				.pin_oe_n_out  (lead_oe_n_out[g*LEADS +: LEADS])
			);
		end
	endgenerate

	// Read multiplexer; a read only samples, it never touches the banks
	// Status reads return levels sampled at the previous edge, so a lead change
	// shows up in a read one cycle later
	reg [LEADS-1:0]        rd_field;
	reg [`LCCL_DATA_W-1:0] rd_word;
	integer                k;

	always @* begin
		rd_field = {LEADS{1'b0}};
		for (k = 0; k < CHANS; k = k + 1) begin
			if (mem_chan_in == k[CHAN_W-1:0]) begin
				if (addr_dir)
					rd_field = dir_all[k*LEADS +: LEADS];
				else if (addr_out)
					rd_field = value_all[k*LEADS +: LEADS];
				else if (addr_state)
					rd_field = state_all[k*LEADS +: LEADS];
			end
		end
		rd_word = {`LCCL_PAD_ZERO, rd_field};
	end

	reg [`LCCL_DATA_W-1:0] rdata_reg;
	reg [`LCCL_DATA_W-1:0] rdata_next;
	reg                    rvalid_reg;

	// Read data hold until the next read; a foreign location reads as zero
	always @* begin
		rdata_next = rdata_reg;
		if (mem_rd_in)
			rdata_next = rd_word;
	end

	// Valid is a one-cycle pulse after each read strobe

	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_reg  <= `LCCL_BYTE_ZERO;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= mem_rd_in;
		end
	end

	assign mem_rdata_out  = rdata_reg;
	assign mem_rvalid_out = rvalid_reg;

	// Fast scan: bits 0 and 1 of every channel's actual lead state
	// Built from the same samples as the status location, so the two agree
	reg [SCAN_W-1:0] scan_pack;
	integer          n;

	always @* begin
		scan_pack = {SCAN_W{1'b0}};
		for (n = 0; n < CHANS; n = n + 1) begin
			scan_pack[`LCCL_SCAN_BITS*n + `LCCL_SCAN_LO] = state_all[n*LEADS + `LCCL_SCAN_LO];
			scan_pack[`LCCL_SCAN_BITS*n + `LCCL_SCAN_HI] = state_all[n*LEADS + `LCCL_SCAN_HI];
		end
	end

	reg [SCAN_W-1:0] scan_reg;
	reg [SCAN_W-1:0] scan_next;
	reg              scan_valid_reg;

	always @* begin
		scan_next = scan_reg;
		if (scan_req_in)
			scan_next = scan_pack;
	end

	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scan_reg       <= {SCAN_W{1'b0}};
			scan_valid_reg <= 1'b0;
		end else begin
			scan_reg       <= scan_next;
			scan_valid_reg <= scan_req_in;
		end
	end

	assign scan_data_out  = scan_reg;
	assign scan_valid_out = scan_valid_reg;

endmodule
